// ==== rtl/qbp_pin_cell.sv ====
// one 8-bit quasi-bidirectional port: latch, pull control, pin sampling
// assumes pin inputs synchronous to ref_clk; outputs are all flops
`timescale 1ns/1ps
module qbp_pin_cell
    import qbp_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // software side
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  latch_q,
    output logic      [7:0]  rd_q,
    // alternate and memory function steering
    input  wire logic [7:0]  alt_out,
    input  wire logic [7:0]  mem_sel,
    input  wire logic [7:0]  mem_val,
    // pin
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o_q,
    output logic      [7:0]  pin_oe_q,
    output logic      [7:0]  weak_pu_q
);

    logic [7:0]          drive_d;
    logic [7:0]          prev_q;
    logic [7:0]          rise;
    logic [7:0]          pulse_on;

    // alternate output only reaches the pin while the latch holds 1
    assign drive_d = (mem_sel & mem_val) | (~mem_sel & latch_q & alt_out);
    assign rise    = drive_d & ~prev_q & ~mem_sel;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            latch_q <= PORT_RESET;
        end else if (clk_en && wr_en) begin
            latch_q <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_q <= PORT_RESET;
        end else if (clk_en) begin
            rd_q <= pin_i;
        end
    end

    // ------------------------------------------------------------
    // momentary strong pull-up, one counter per bit
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < PORT_W; b++) begin : g_bit
            logic [PU_CNT_W-1:0] cnt_q;
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    cnt_q <= PU_CNT_ZERO;
                end else if (clk_en) begin
                    if (rise[b]) begin
                        cnt_q <= STRONG_PU_CYC;
                    end else if (cnt_q != PU_CNT_ZERO) begin
                        cnt_q <= cnt_q - PU_CNT_ONE;
                    end
                end
            end
            // rise cycle plus the remaining count gives STRONG_PU_CYC cycles
            assign pulse_on[b] = rise[b] | (cnt_q > PU_CNT_ONE);
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            prev_q    <= PORT_RESET;
            pin_o_q   <= PORT_RESET;
            pin_oe_q  <= OE_RESET;
            weak_pu_q <= PORT_RESET;
        end else if (clk_en) begin
            prev_q    <= drive_d;
            pin_o_q   <= drive_d;
            // strong low while 0, strong high only during the pulse or on memory-selected bits
            pin_oe_q  <= ~drive_d | mem_sel | pulse_on;
            weak_pu_q <= drive_d & ~mem_sel;
        end
    end

endmodule // qbp_pin_cell

// ==== rtl/qbp_pkg.sv ====
// constants shared by the quasi-bidirectional port block
// assumes a single 100 MHz core clock and a synchronous active-low reset
package qbp_pkg;

    // ------------------------------------------------------------
    // widths and port indices
    // ------------------------------------------------------------
    localparam int PORT_W   = 8;
    localparam int NUM_QB   = 3;
    localparam int IDX_P3   = 0;
    localparam int IDX_P4   = 1;
    localparam int IDX_P5   = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_RESET  = 8'hFF;
    localparam logic [7:0] OE_RESET    = 8'h00;
    localparam logic [7:0] ALT_IDLE    = 8'hFF;
    localparam logic       BIT_IDLE    = 1'h1;

    // ------------------------------------------------------------
    // strong pull-up pulse timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int STRONG_PU_NS  = 20;
    localparam int PU_CNT_W      = 4;
    localparam logic [PU_CNT_W-1:0] STRONG_PU_CYC =
        PU_CNT_W'((STRONG_PU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [PU_CNT_W-1:0] PU_CNT_ZERO = 4'h0;
    localparam logic [PU_CNT_W-1:0] PU_CNT_ONE  = 4'h1;

    // ------------------------------------------------------------
    // alternate function bit positions, port 3
    // ------------------------------------------------------------
    localparam int P3_SER_A_RX = 0;
    localparam int P3_SER_A_TX = 1;
    localparam int P3_IRQ0     = 2;
    localparam int P3_IRQ1     = 3;
    localparam int P3_TMR0     = 4;
    localparam int P3_TMR1     = 5;
    localparam int P3_WR_N     = 6;
    localparam int P3_RD_N     = 7;

    // ------------------------------------------------------------
    // alternate function bit positions, port 5
    // ------------------------------------------------------------
    localparam int P5_CAN_A_TX = 0;
    localparam int P5_CAN_A_RX = 1;
    localparam int P5_CAN_B_RX = 2;
    localparam int P5_CAN_B_TX = 3;

endpackage

// ==== rtl/qbp_port_pins.sv ====
// quasi-bidirectional ports 3, 4 and 5 plus the high address byte port
// assumes core-side strobes and pins synchronous to ref_clk (100 MHz)
`timescale 1ns/1ps
module qbp_port_pins
    import qbp_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,

    // port latch writes from the core
    input  wire logic        wr_p2,
    input  wire logic        wr_p3,
    input  wire logic        wr_p4,
    input  wire logic        wr_p5,
    input  wire logic [7:0]  wr_data,

    // port reads to the core
    output logic      [7:0]  p2_rdata,
    output logic      [7:0]  p3_rdata,
    output logic      [7:0]  p4_rdata,
    output logic      [7:0]  p5_rdata,

    // high address byte control
    input  wire logic        mem_access,
    input  wire logic        movx_ri,
    input  wire logic [7:0]  mem_addr_hi,

    // port 4 memory signals
    input  wire logic [3:0]  mem_addr_ext,
    input  wire logic [3:0]  prog_select_n,
    input  wire logic [7:0]  port4_function_select,

    // port 3 alternate functions
    input  wire logic        serial_a_transmit,
    input  wire logic        clock_out_enable,
    input  wire logic        clock_out_pin,
    input  wire logic        ext_wr_strobe_n,
    input  wire logic        ext_rd_strobe_n,

    // port 3 alternate inputs to the core
    output logic             serial_a_receive,
    output logic             ext_irq_zero_pin,
    output logic             ext_irq_one_pin,
    output logic             timer_zero_input,
    output logic             timer_one_input,

    // port 5 alternate functions
    input  wire logic        serial_b_relocate,
    input  wire logic        serial_b_transmit,
    input  wire logic        can_a_transmit,
    input  wire logic        can_b_transmit,
    input  wire logic [3:0]  periph_select_n,

    // port 5 alternate inputs to the core
    output logic             can_a_receive,
    output logic             can_b_receive,
    output logic             serial_b_receive,

    // high address byte pins, output only
    output logic      [7:0]  p2_pin_o,

    // port 3 pins
    input  wire logic [7:0]  p3_pin_i,
    output logic      [7:0]  p3_pin_o,
    output logic      [7:0]  p3_pin_oe,
    output logic      [7:0]  p3_weak_pu,

    // port 4 pins
    input  wire logic [7:0]  p4_pin_i,
    output logic      [7:0]  p4_pin_o,
    output logic      [7:0]  p4_pin_oe,
    output logic      [7:0]  p4_weak_pu,

    // port 5 pins
    input  wire logic [7:0]  p5_pin_i,
    output logic      [7:0]  p5_pin_o,
    output logic      [7:0]  p5_pin_oe,
    output logic      [7:0]  p5_weak_pu
);

    // ------------------------------------------------------------
    // per-port arrays feeding the generated cells
    // ------------------------------------------------------------
    logic [NUM_QB-1:0]           qb_wr;
    logic [NUM_QB-1:0][7:0]      qb_pin_i;
    logic [NUM_QB-1:0][7:0]      qb_alt;
    logic [NUM_QB-1:0][7:0]      qb_mem_sel;
    logic [NUM_QB-1:0][7:0]      qb_mem_val;
    logic [NUM_QB-1:0][7:0]      qb_rd;
    logic [NUM_QB-1:0][7:0]      qb_pin_o;
    logic [NUM_QB-1:0][7:0]      qb_pin_oe;
    logic [NUM_QB-1:0][7:0]      qb_weak_pu;

    logic [7:0]                  p2_latch_q;
    logic [7:0]                  p2_pin_q;
    logic                        ser_b_rx_q;

    // ------------------------------------------------------------
    // write strobes and pin levels, one slot per port
    // ------------------------------------------------------------
    always_comb begin
        qb_wr[IDX_P3] = wr_p3;
        qb_wr[IDX_P4] = wr_p4;
        qb_wr[IDX_P5] = wr_p5;
    end

    always_comb begin
        qb_pin_i[IDX_P3] = p3_pin_i;
        qb_pin_i[IDX_P4] = p4_pin_i;
        qb_pin_i[IDX_P5] = p5_pin_i;
    end

    // ------------------------------------------------------------
    // alternate outputs
    // ------------------------------------------------------------
    // whole array in one process, so it keeps a single driver
    // input-only functions leave their bit at 1 so the pin stays readable
    always_comb begin
        qb_alt = {NUM_QB{ALT_IDLE}};

        // port 3: serial A, clock out, data strobes
        qb_alt[IDX_P3][P3_SER_A_TX] = serial_a_transmit;
        qb_alt[IDX_P3][P3_TMR1]     = clock_out_enable ?
                                      clock_out_pin : BIT_IDLE;
        qb_alt[IDX_P3][P3_WR_N]     = ext_wr_strobe_n;
        qb_alt[IDX_P3][P3_RD_N]     = ext_rd_strobe_n;

        // port 4: memory pins are push-pull, alternate stays idle

        // port 5: CAN A, CAN B or relocated serial B, peripheral selects
        qb_alt[IDX_P5][P5_CAN_A_TX] = can_a_transmit;
        qb_alt[IDX_P5][P5_CAN_B_TX] = serial_b_relocate ?
                                      serial_b_transmit :
                                      can_b_transmit;
        qb_alt[IDX_P5][7:4]         = periph_select_n;
    end

    // ------------------------------------------------------------
    // port 4 memory interface
    // ------------------------------------------------------------
    // memory pins are push-pull, so the latch has no say on them
    always_comb begin
        qb_mem_sel         = {NUM_QB{8'h00}};
        qb_mem_sel[IDX_P4] = port4_function_select;
    end

    always_comb begin
        qb_mem_val         = {NUM_QB{8'h00}};
        qb_mem_val[IDX_P4] = {mem_addr_ext, prog_select_n};
    end

    // ------------------------------------------------------------
    // quasi-bidirectional port cells
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NUM_QB; p++) begin : g_port
            qbp_pin_cell u_cell (
                .ref_clk   (ref_clk),
                .resetn    (resetn),
                .clk_en    (clk_en),
                .wr_en     (qb_wr[p]),
                .wr_data   (wr_data),
                .latch_q   (),
                .rd_q      (qb_rd[p]),
                .alt_out   (qb_alt[p]),
                .mem_sel   (qb_mem_sel[p]),
                .mem_val   (qb_mem_val[p]),
                .pin_i     (qb_pin_i[p]),
                .pin_o_q   (qb_pin_o[p]),
                .pin_oe_q  (qb_pin_oe[p]),
                .weak_pu_q (qb_weak_pu[p])
            );
        end
    endgenerate

    assign p3_pin_o   = qb_pin_o[IDX_P3];
    assign p3_pin_oe  = qb_pin_oe[IDX_P3];
    assign p3_weak_pu = qb_weak_pu[IDX_P3];
    assign p4_pin_o   = qb_pin_o[IDX_P4];
    assign p4_pin_oe  = qb_pin_oe[IDX_P4];
    assign p4_weak_pu = qb_weak_pu[IDX_P4];
    assign p5_pin_o   = qb_pin_o[IDX_P5];
    assign p5_pin_oe  = qb_pin_oe[IDX_P5];
    assign p5_weak_pu = qb_weak_pu[IDX_P5];

    // reads return the sampled pin, not the latch
    assign p3_rdata = qb_rd[IDX_P3];
    assign p4_rdata = qb_rd[IDX_P4];
    assign p5_rdata = qb_rd[IDX_P5];

    // ------------------------------------------------------------
    // alternate inputs, taken from the sampled pins
    // ------------------------------------------------------------
    assign serial_a_receive = qb_rd[IDX_P3][P3_SER_A_RX];
    assign ext_irq_zero_pin = qb_rd[IDX_P3][P3_IRQ0];
    assign ext_irq_one_pin  = qb_rd[IDX_P3][P3_IRQ1];
    assign timer_zero_input = qb_rd[IDX_P3][P3_TMR0];
    assign timer_one_input  = qb_rd[IDX_P3][P3_TMR1];
    assign can_a_receive    = qb_rd[IDX_P5][P5_CAN_A_RX];
    assign can_b_receive    = qb_rd[IDX_P5][P5_CAN_B_RX];
    assign serial_b_receive = ser_b_rx_q;

    // serial B receive idles high when its pins live elsewhere
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ser_b_rx_q <= BIT_IDLE;
        end else if (clk_en) begin
            ser_b_rx_q <= serial_b_relocate ?
                          p5_pin_i[P5_CAN_B_RX] : BIT_IDLE;
        end
    end

    // ------------------------------------------------------------
    // high address byte port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            p2_latch_q <= PORT_RESET;
        end else if (clk_en && wr_p2) begin
            p2_latch_q <= wr_data;
        end
    end

    // outside memory accesses and on 8-bit-pointer moves the latch reaches the pins
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            p2_pin_q <= PORT_RESET;
        end else if (clk_en) begin
            if (mem_access && movx_ri) begin
                p2_pin_q <= p2_latch_q;
            end else if (mem_access) begin
                p2_pin_q <= mem_addr_hi;
            end else begin
                p2_pin_q <= p2_latch_q;
            end
        end
    end

    assign p2_pin_o = p2_pin_q;
    assign p2_rdata = p2_latch_q;

endmodule // qbp_port_pins

// ==== tb/qbp_pin_model.sv ====
// partner: outside circuit on one 8-bit quasi-bidirectional port
// assumes pin controls from the device and a pull-low mask from the bench
`timescale 1ns/1ps
module qbp_pin_model (
    // clock
    input  wire logic       ref_clk,
    // device side of the pins
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] weak_pu,
    // outside circuit
    input  wire logic [7:0] ext_low,
    output logic      [7:0] pin_i
);
    // undriven bits wander so a stale level never passes by luck
    logic [7:0] float_q = 8'h00;
    always_ff @(posedge ref_clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (pin_oe[b])
                pin_i[b] = pin_o[b];
            else if (ext_low[b])
                pin_i[b] = 1'h0;
            else
                pin_i[b] = weak_pu[b] ? 1'h1 : float_q[b];
        end
    end
endmodule // qbp_pin_model

// ==== tb/qbp_properties.sv ====
// checker: pin relations of the port block seen at its boundary
// assumes binding to qbp_port_pins, one clock domain
`timescale 1ns/1ps
module qbp_properties (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    // core side
    input wire logic       wr_p3,
    input wire logic [7:0] wr_data,
    input wire logic       mem_access,
    input wire logic       movx_ri,
    input wire logic [7:0] mem_addr_hi,
    input wire logic [3:0] mem_addr_ext,
    input wire logic [3:0] prog_select_n,
    input wire logic [7:0] port4_function_select,
    input wire logic       ext_wr_strobe_n,
    input wire logic       can_a_transmit,
    input wire logic       serial_b_relocate,
    input wire logic       serial_b_transmit,
    input wire logic       serial_b_receive,
    // pins
    input wire logic [7:0] p2_pin_o,
    input wire logic [7:0] p3_pin_i,
    input wire logic [7:0] p3_rdata,
    input wire logic [7:0] p3_pin_o,
    input wire logic [7:0] p3_pin_oe,
    input wire logic [7:0] p3_weak_pu,
    input wire logic [7:0] p4_pin_o,
    input wire logic [7:0] p4_pin_oe,
    input wire logic [7:0] p5_pin_o
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_HI_ADDR: assert property (clk_en && mem_access && !movx_ri |=>
        p2_pin_o == $past(mem_addr_hi)) else $error("high address byte wrong");
    AST_PIN_READ: assert property (clk_en |=> p3_rdata == $past(p3_pin_i))
        else $error("port read not pin level");
    AST_PULL_DOWN: assert property (wr_p3 && clk_en && wr_data == 8'h00 ##1 clk_en
        |=> p3_pin_oe == 8'hFF && p3_pin_o == 8'h00) else $error("no strong pull-down");
    AST_NO_FIGHT: assert property ((p3_pin_oe & ~p3_pin_o & p3_weak_pu) == 8'h00)
        else $error("weak pull-up on while pulling down");
    AST_KICK: assert property ($rose(p3_pin_o[4]) |-> p3_pin_oe[4] ##1 p3_pin_oe[4]
        ##1 !p3_pin_oe[4]) else $error("strong pull-up pulse wrong length");
    AST_MEM_P4: assert property (clk_en && port4_function_select == 8'hFF |=>
        p4_pin_oe == 8'hFF && p4_pin_o == {$past(mem_addr_ext), $past(prog_select_n)})
        else $error("memory signals not on port 4");
    AST_MEM_BIT: assert property (clk_en && port4_function_select[7] |=>
        p4_pin_oe[7] && p4_pin_o[7] == $past(mem_addr_ext[3])) else $error("pin 7 select");
    AST_WR_STROBE: assert property (clk_en && !ext_wr_strobe_n |=>
        p3_pin_oe[6] && !p3_pin_o[6]) else $error("write strobe not on pin");
    AST_CAN_TX: assert property (clk_en && !can_a_transmit |=> !p5_pin_o[0])
        else $error("can a transmit not on pin");
    AST_SER_B_TX: assert property (clk_en && serial_b_relocate && !serial_b_transmit
        |=> !p5_pin_o[3]) else $error("serial b transmit not relocated");
    AST_SER_B_IDLE: assert property (clk_en && !serial_b_relocate |=> serial_b_receive)
        else $error("serial b receive not idle");

    cover property (mem_access && movx_ri);
    cover property ($rose(p3_pin_o[4]));
    cover property (serial_b_relocate && !serial_b_transmit);
endmodule // qbp_properties

// ==== tb/testbench.sv ====
// testbench: drives the port block and three pin models, judges pins and reads
// assumes the design under rtl/, checker and pin model under tb/
`timescale 1ns/1ps
module testbench;
    import qbp_pkg::*;
    logic       ref_clk = 1'h0;
    logic       resetn, clk_en, wr_p2, wr_p3, wr_p4, wr_p5, mem_access, movx_ri;
    logic       serial_a_transmit, clock_out_enable, clock_out_pin, ext_wr_strobe_n;
    logic       ext_rd_strobe_n, serial_b_relocate, serial_b_transmit, can_a_transmit;
    logic       can_b_transmit, serial_a_receive, ext_irq_zero_pin, ext_irq_one_pin;
    logic       timer_zero_input, timer_one_input, can_a_receive, can_b_receive;
    logic       serial_b_receive;
    logic [3:0] mem_addr_ext, prog_select_n, periph_select_n;
    logic [7:0] wr_data, mem_addr_hi, port4_function_select, p2_rdata, p3_rdata, p4_rdata;
    logic [7:0] p5_rdata, p2_pin_o, p3_pin_i, p3_pin_o, p3_pin_oe, p3_weak_pu, p4_pin_i;
    logic [7:0] p4_pin_o, p4_pin_oe, p4_weak_pu, p5_pin_i, p5_pin_o, p5_pin_oe, p5_weak_pu;
    logic [7:0] p3_low, p4_low, p5_low;
    int         failures = 0;
    int         num_checks = 0;

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    qbp_port_pins i_qbp_port_pins (
        .ref_clk, .resetn, .clk_en, .wr_p2, .wr_p3, .wr_p4, .wr_p5, .wr_data,
        .p2_rdata, .p3_rdata, .p4_rdata, .p5_rdata, .mem_access, .movx_ri, .mem_addr_hi,
        .mem_addr_ext, .prog_select_n, .port4_function_select, .serial_a_transmit,
        .clock_out_enable, .clock_out_pin, .ext_wr_strobe_n, .ext_rd_strobe_n,
        .serial_a_receive, .ext_irq_zero_pin, .ext_irq_one_pin, .timer_zero_input,
        .timer_one_input, .serial_b_relocate, .serial_b_transmit, .can_a_transmit,
        .can_b_transmit, .periph_select_n, .can_a_receive, .can_b_receive,
        .serial_b_receive, .p2_pin_o, .p3_pin_i, .p3_pin_o, .p3_pin_oe, .p3_weak_pu,
        .p4_pin_i, .p4_pin_o, .p4_pin_oe, .p4_weak_pu, .p5_pin_i, .p5_pin_o, .p5_pin_oe,
        .p5_weak_pu);
    qbp_pin_model u_p3 (.ref_clk, .pin_o(p3_pin_o), .pin_oe(p3_pin_oe),
        .weak_pu(p3_weak_pu), .ext_low(p3_low), .pin_i(p3_pin_i));
    qbp_pin_model u_p4 (.ref_clk, .pin_o(p4_pin_o), .pin_oe(p4_pin_oe),
        .weak_pu(p4_weak_pu), .ext_low(p4_low), .pin_i(p4_pin_i));
    qbp_pin_model u_p5 (.ref_clk, .pin_o(p5_pin_o), .pin_oe(p5_pin_oe),
        .weak_pu(p5_weak_pu), .ext_low(p5_low), .pin_i(p5_pin_i));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input int p, input logic [7:0] d);
        wr_data = d;
        {wr_p2, wr_p3, wr_p4, wr_p5} = 4'h8 >> (p - 2);
        step(1);
        {wr_p2, wr_p3, wr_p4, wr_p5} = 4'h0;
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({p3_pin_oe, p4_pin_oe, p5_pin_oe, p2_pin_o}, 32'h000000FF);
        chk({p3_weak_pu, p4_weak_pu, p5_weak_pu, p2_rdata}, 32'hFFFFFFFF);
        chk({p3_rdata, p4_rdata, p5_rdata, p3_pin_o}, 32'hFFFFFFFF);
        $display("t_reset done");
    endtask
    task automatic t_pull();
        wr(3, 8'h00);
        step(1);
        chk({p3_pin_o, p3_pin_oe, p3_weak_pu}, 24'h00FF00);
        step(4);
        chk({p3_pin_oe, p3_rdata}, 16'hFF00);
        wr(3, 8'hFF);
        step(1);
        chk({p3_pin_o, p3_pin_oe, p3_weak_pu}, 24'hFFFFFF);
        step(1);
        chk(p3_pin_oe, 8'hFF);
        step(1);
        chk({p3_pin_oe, p3_weak_pu}, 16'h00FF);
        p3_low = 8'h81;
        step(1);
        chk(p3_rdata, 8'h7E);
        p3_low = 8'h00;
        wr(3, 8'h00);
        step(3);
        resetn = 1'h0;
        step(2);
        resetn = 1'h1;
        step(1);
        chk({p3_pin_oe, p3_weak_pu}, 16'h00FF);
        $display("t_pull done");
    endtask
    task automatic t_hi();
        wr(2, 8'h3C);
        step(1);
        chk({p2_rdata, p2_pin_o}, 16'h3C3C);
        mem_access = 1'h1;
        mem_addr_hi = 8'hA7;
        step(1);
        chk(p2_pin_o, 8'hA7);
        movx_ri = 1'h1;
        step(1);
        chk(p2_pin_o, 8'h3C);
        mem_access = 1'h0;
        movx_ri = 1'h0;
        $display("t_hi done");
    endtask
    task automatic t_mem4();
        mem_addr_ext = 4'hA;
        prog_select_n = 4'h5;
        port4_function_select = 8'hF0;
        step(1);
        chk({p4_pin_o, p4_pin_oe, p4_weak_pu}, 24'hAFF00F);
        port4_function_select = 8'h0F;
        step(3);
        chk({p4_pin_o, p4_pin_oe, p4_weak_pu}, 24'hF50FF0);
        port4_function_select = 8'hFF;
        step(1);
        chk({p4_pin_o, p4_pin_oe}, 16'hA5FF);
        port4_function_select = 8'h00;
        step(3);
        $display("t_mem4 done");
    endtask
    task automatic t_p3alt();
        clock_out_enable = 1'h1;
        {serial_a_transmit, clock_out_pin, ext_wr_strobe_n, ext_rd_strobe_n} = 4'h1;
        step(1);
        chk({p3_pin_o, p3_pin_oe}, 16'h9D62);
        {serial_a_transmit, clock_out_pin, ext_wr_strobe_n, ext_rd_strobe_n} = 4'hE;
        step(1);
        // pins 1, 5 and 6 go 0 to 1 here, so their strong pull-up kicks in
        chk({p3_pin_o, p3_pin_oe}, 16'h7FE2);
        ext_rd_strobe_n = 1'h1;
        clock_out_enable = 1'h0;
        step(3);
        p3_low = 8'h15;
        step(1);
        chk({serial_a_receive, ext_irq_zero_pin, ext_irq_one_pin, timer_zero_input,
             timer_one_input, p3_rdata}, {5'h05, 8'hEA});
        p3_low = 8'h00;
        $display("t_p3alt done");
    endtask
    task automatic t_p5();
        {can_a_transmit, can_b_transmit, periph_select_n} = 6'h2A;
        p5_low = 8'h06;
        step(1);
        chk({p5_pin_o, can_a_receive, can_b_receive, serial_b_receive},
            {8'hA7, 3'h1});
        {serial_b_relocate, can_a_transmit, can_b_transmit, serial_b_transmit} = 4'h8;
        p5_low = 8'h04;
        step(1);
        chk({p5_pin_o, can_a_receive, can_b_receive, serial_b_receive},
            {8'hA6, 3'h4});
        {serial_b_relocate, can_a_transmit, can_b_transmit, serial_b_transmit} = 4'h7;
        periph_select_n = 4'hF;
        p5_low = 8'h00;
        step(3);
        $display("t_p5 done");
    endtask
    task automatic t_hold();
        // frozen clock enable must swallow the write entirely
        clk_en = 1'h0;
        wr(5, 8'h00);
        step(2);
        chk({p5_pin_oe, p5_weak_pu}, 16'h00FF);
        clk_en = 1'h1;
        step(2);
        // a leaked write would have reached the pins by now
        chk({p5_pin_oe, p5_weak_pu, p5_rdata}, 24'h00FFFF);
        $display("t_hold done");
    endtask

    initial begin
        {resetn, wr_p2, wr_p3, wr_p4, wr_p5, mem_access, movx_ri} = 7'h00;
        {clk_en, serial_a_transmit, clock_out_pin, ext_wr_strobe_n} = 4'hF;
        {ext_rd_strobe_n, serial_b_transmit, can_a_transmit, can_b_transmit} = 4'hF;
        {clock_out_enable, serial_b_relocate} = 2'h0;
        {mem_addr_ext, prog_select_n, periph_select_n} = 12'h00F;
        {wr_data, mem_addr_hi, port4_function_select} = 24'h000000;
        {p3_low, p4_low, p5_low} = 24'h000000;
        step(10);
        resetn = 1'h1;
        step(1);
        t_reset();
        t_pull();
        t_hi();
        t_mem4();
        t_p3alt();
        t_p5();
        t_hold();
        summarize();
    end

    // the tests need well under a thousand cycles
    initial begin
        #20000;
        failures++;
        summarize();
    end
endmodule // testbench

bind qbp_port_pins qbp_properties i_qbp_properties (
    .ref_clk, .resetn, .clk_en, .wr_p3, .wr_data, .mem_access, .movx_ri, .mem_addr_hi,
    .mem_addr_ext, .prog_select_n, .port4_function_select, .ext_wr_strobe_n,
    .can_a_transmit, .serial_b_relocate, .serial_b_transmit, .serial_b_receive,
    .p2_pin_o, .p3_pin_i, .p3_rdata, .p3_pin_o, .p3_pin_oe, .p3_weak_pu, .p4_pin_o,
    .p4_pin_oe, .p5_pin_o);
